// ===== ers_consts.svh
/*
  Constants for the scrub controller: widths, reset values, default counts.
  Assumes it is included by the package only; the controller uses its macros from there.
*/
`ifndef ERS_CONSTS_SVH
`define ERS_CONSTS_SVH

// Address, codeword and counter widths
`define ERS_AW 10
`define ERS_WW 39
`define ERS_CNTW 32

// Scrub range reset defaults
`define ERS_START_DEF 10'h000
`define ERS_END_DEF 10'h3FF

// Refresh timer defaults
`define ERS_PRESCALE_DEF 16
`define ERS_TIMEOUT_DEF 64

// Sequencer timing counts in clock cycles
`define ERS_RESUME_CYC 4
`define ERS_RDLAT_CYC 2
`define ERS_WBACK_CYC 3
`define ERS_FIN_SHARED 2'h1
`define ERS_FIN_SPLIT 2'h2

`endif

// ===== ers_pkg.sv
/*
  Types of the scrub controller: sequencer states, flag pair, state record.
  Assumes ers_consts.svh is on the include path.
*/
`include "ers_consts.svh"

package ers_pkg;

  typedef logic [`ERS_AW-1:0] ers_addr_t;
  typedef logic [`ERS_WW-1:0] ers_word_t;
  typedef logic [`ERS_CNTW-1:0] ers_cnt_t;

  // Sequencer states, one-hot
  typedef enum logic [6:0] {
    ERS_INIT = 7'h01,
    ERS_IDLE = 7'h02,
    ERS_RESUME = 7'h04,
    ERS_SUSP = 7'h08,
    ERS_READ = 7'h10,
    ERS_WAIT = 7'h20,
    ERS_WBACK = 7'h40
  } ers_state_e;

  // Decoder flag pair: 00 clean, 10 corrected, 01 double error
  typedef struct packed {
    logic corr;
    logic err;
  } ers_flags_s;

  // Whole controller state
  typedef struct packed {
    ers_state_e state;
    logic holdS1;
    logic holdS2;
    ers_cnt_t pre;
    ers_cnt_t div;
    logic pend;
    logic dly;
    ers_addr_t cur;
    ers_cnt_t cnt;
    logic [1:0] finCnt;
    ers_addr_t ramAddr;
    logic ramRen;
    logic ramWen;
    logic ramWrZero;
    logic userWrBlock;
    logic scrubActive;
    logic scrubFix;
    logic scrubFinished;
    logic scrubDeferred;
    logic initDone;
    logic timeoutPulse;
    ers_flags_s userFlags;
    ers_word_t rdDataOut;
  } ers_st_s;

endpackage : ers_pkg

// ===== ers_scrub_ctrl.sv
/*
  Scrub controller for a SECDED protected RAM: refresh timer, optional zero
  fill after reset, scrub sequencer with user priority, flag outputs.
  Assumes the codec sits outside: the RAM write mux picks an encoded zero
  word when ramWrZero is high, else the corrected codeword from the decoder.
  decFlags and rdData arrive on clk; userAccessHold may come from another
  clock and is synchronised here.
*/
`timescale 1ns/1ns
`default_nettype none

module ers_scrub_ctrl
  import ers_pkg::*;
#(
  parameter int PRESCALE_WIDTH = `ERS_PRESCALE_DEF,
  parameter int TIMEOUT_COUNT = `ERS_TIMEOUT_DEF,
  parameter ers_pkg::ers_addr_t SCRUB_START_ADDR = `ERS_START_DEF,
  parameter ers_pkg::ers_addr_t SCRUB_END_ADDR = `ERS_END_DEF,
  parameter bit SCRUB_ON = 1'b1,
  parameter bit INIT_RAM = 1'b1,
  parameter bit SHARED_CLOCK_SEL = 1'b1,
  parameter int RESUME_CYC = `ERS_RESUME_CYC,
  parameter int RDLAT_CYC = `ERS_RDLAT_CYC,
  parameter int WBACK_CYC = `ERS_WBACK_CYC
)(
  input wire logic clk,
  input wire logic rst_n,
  input wire logic userAccessHold,
  input wire logic rdValid,
  input wire ers_pkg::ers_word_t rdData,
  input wire ers_pkg::ers_flags_s decFlags,
  output ers_pkg::ers_addr_t ramAddr,
  output logic ramRen,
  output logic ramWen,
  output logic ramWrZero,
  output logic userWrBlock,
  output ers_pkg::ers_word_t rdDataOut,
  output ers_pkg::ers_flags_s userFlags,
  output logic timeoutPulse,
  output logic scrubActive,
  output logic scrubFix,
  output logic scrubFinished,
  output logic scrubDeferred,
  output logic initDone
);
  import ers_pkg::*;

  // ----------------------------------------------------------------
  // Derived constants
  // ----------------------------------------------------------------
  // Zero fill only exists together with scrubbing
  localparam bit INIT_EN = INIT_RAM && SCRUB_ON;
  localparam ers_cnt_t PRE_LAST = ers_cnt_t'((64'h1 << PRESCALE_WIDTH) - 64'h1);
  localparam ers_cnt_t DIV_LAST = ers_cnt_t'(TIMEOUT_COUNT - 1);
  localparam ers_cnt_t RES_CNT = ers_cnt_t'(RESUME_CYC);
  localparam ers_cnt_t RD_CNT = ers_cnt_t'(RDLAT_CYC);
  localparam ers_cnt_t WB_CNT = ers_cnt_t'(WBACK_CYC);
  localparam logic [1:0] FIN_LEN = SHARED_CLOCK_SEL ? `ERS_FIN_SHARED : `ERS_FIN_SPLIT;
  localparam ers_state_e RST_STATE = INIT_EN ? ERS_INIT : ERS_IDLE;

  ers_st_s st_r;
  ers_st_s st_nxt;
  logic hold;
  logic tick;
  logic tmo;
  logic scrubbing;

  // ----------------------------------------------------------------
  // Next state
  // ----------------------------------------------------------------
  // Whole sequencer in one pass; pending timeout is set after any clear
  always_comb
  begin
    st_nxt = st_r;
    st_nxt.holdS1 = userAccessHold;
    st_nxt.holdS2 = st_r.holdS1;
    hold = st_r.holdS2;
    st_nxt.ramRen = 1'b0;
    st_nxt.ramWen = 1'b0;
    st_nxt.scrubFix = 1'b0;
    scrubbing = (st_r.state == ERS_READ) || (st_r.state == ERS_WAIT) ||
                (st_r.state == ERS_WBACK);

    // Refresh timer
    tick = (st_r.pre == PRE_LAST);
    st_nxt.pre = tick ? '0 : st_r.pre + ers_cnt_t'(1);
    tmo = 1'b0;
    if (tick)
    begin
      if (st_r.div == DIV_LAST)
      begin
        st_nxt.div = '0;
        tmo = SCRUB_ON;
      end
      else
      begin
        st_nxt.div = st_r.div + ers_cnt_t'(1);
      end
    end
    st_nxt.timeoutPulse = tmo;

    // Finished pulse stretcher
    if (st_r.finCnt != 2'h0)
    begin
      st_nxt.finCnt = st_r.finCnt - 2'h1;
    end

    unique case (st_r.state)
      ERS_INIT:
      begin
        // Fill one encoded zero word per cycle
        st_nxt.ramAddr = st_r.cur;
        st_nxt.ramWen = 1'b1;
        st_nxt.ramWrZero = 1'b1;
        if (st_r.cur == SCRUB_END_ADDR)
        begin
          st_nxt.initDone = 1'b1;
          st_nxt.state = ERS_IDLE;
        end
        else
        begin
          st_nxt.cur = st_r.cur + ers_addr_t'(1);
        end
      end
      ERS_IDLE:
      begin
        st_nxt.initDone = 1'b1;
        st_nxt.ramWrZero = 1'b0;
        if (st_r.pend && hold)
        begin
          st_nxt.dly = 1'b1;
        end
        else if (st_r.pend)
        begin
          // Session start still waits out the resume gap
          st_nxt.pend = 1'b0;
          st_nxt.scrubDeferred = st_r.dly;
          st_nxt.dly = 1'b0;
          st_nxt.cur = SCRUB_START_ADDR;
          st_nxt.cnt = RES_CNT;
          st_nxt.state = ERS_RESUME;
        end
      end
      ERS_RESUME:
      begin
        // Any hold inside the gap restarts the wait
        if (hold)
        begin
          st_nxt.state = ERS_SUSP;
        end
        else if (st_r.cnt <= ers_cnt_t'(1))
        begin
          st_nxt.state = ERS_READ;
        end
        else
        begin
          st_nxt.cnt = st_r.cnt - ers_cnt_t'(1);
        end
      end
      ERS_SUSP:
      begin
        if (!hold)
        begin
          st_nxt.cnt = RES_CNT;
          st_nxt.state = ERS_RESUME;
        end
      end
      ERS_READ:
      begin
        if (hold)
        begin
          st_nxt.state = ERS_SUSP;
        end
        else
        begin
          st_nxt.ramAddr = st_r.cur;
          st_nxt.ramRen = 1'b1;
          st_nxt.cnt = RD_CNT;
          st_nxt.state = ERS_WAIT;
        end
      end
      ERS_WAIT:
      begin
        // A hold here drops this word; it is read again after resume
        if (st_r.cnt != '0)
        begin
          st_nxt.cnt = st_r.cnt - ers_cnt_t'(1);
        end
        else if (hold)
        begin
          st_nxt.state = ERS_SUSP;
        end
        else if (decFlags.corr)
        begin
          st_nxt.ramWen = 1'b1;
          st_nxt.cnt = WB_CNT;
          st_nxt.state = ERS_WBACK;
        end
        else if (st_r.cur == SCRUB_END_ADDR)
        begin
          st_nxt.finCnt = FIN_LEN;
          st_nxt.state = ERS_IDLE;
        end
        else
        begin
          st_nxt.cur = st_r.cur + ers_addr_t'(1);
          st_nxt.state = ERS_READ;
        end
      end
      ERS_WBACK:
      begin
        // Not suspended: cutting a writeback short could corrupt the word
        if (st_r.cnt > ers_cnt_t'(1))
        begin
          st_nxt.cnt = st_r.cnt - ers_cnt_t'(1);
        end
        else
        begin
          st_nxt.scrubFix = 1'b1;
          if (st_r.cur == SCRUB_END_ADDR)
          begin
            st_nxt.finCnt = FIN_LEN;
            st_nxt.state = ERS_IDLE;
          end
          else
          begin
            st_nxt.cur = st_r.cur + ers_addr_t'(1);
            st_nxt.state = ERS_READ;
          end
        end
      end
    endcase

    // Set wins over the clear made on session start
    if (tmo)
    begin
      st_nxt.pend = 1'b1;
      if (hold || !st_r.initDone)
      begin
        st_nxt.dly = 1'b1;
      end
    end

    // Status outputs follow the next state so they leave a flop
    // Block must still cover the last fill write, so it follows the present state
    st_nxt.userWrBlock = (st_r.state == ERS_INIT);
    st_nxt.scrubActive = (st_nxt.state == ERS_READ) || (st_nxt.state == ERS_WAIT) ||
                         (st_nxt.state == ERS_WBACK);
    st_nxt.scrubFinished = (st_nxt.finCnt != 2'h0);

    // User flags ride with their data; scrub and init reads stay silent
    st_nxt.rdDataOut = rdData;
    st_nxt.userFlags.corr = rdValid && decFlags.corr && !scrubbing &&
                            st_r.initDone;
    st_nxt.userFlags.err = rdValid && decFlags.err && !scrubbing &&
                           st_r.initDone;
  end

  // ----------------------------------------------------------------
  // State register
  // ----------------------------------------------------------------
  // Synchronous reset; every field takes a constant
  always_ff @(posedge clk)
  begin
    if (!rst_n)
    begin
      st_r <= '0;
      st_r.state <= RST_STATE;
      st_r.cur <= SCRUB_START_ADDR;
      st_r.ramAddr <= SCRUB_START_ADDR;
      st_r.userWrBlock <= INIT_EN;
    end
    else
    begin
      st_r <= st_nxt;
    end
  end

  // ----------------------------------------------------------------
  // Outputs
  // ----------------------------------------------------------------
  assign ramAddr = st_r.ramAddr;
  assign ramRen = st_r.ramRen;
  assign ramWen = st_r.ramWen;
  assign ramWrZero = st_r.ramWrZero;
  assign userWrBlock = st_r.userWrBlock;
  assign rdDataOut = st_r.rdDataOut;
  assign userFlags = st_r.userFlags;
  assign timeoutPulse = st_r.timeoutPulse;
  assign scrubActive = st_r.scrubActive;
  assign scrubFix = st_r.scrubFix;
  assign scrubFinished = st_r.scrubFinished;
  assign scrubDeferred = st_r.scrubDeferred;
  assign initDone = st_r.initDone;

endmodule : ers_scrub_ctrl

`default_nettype wire

// ===== ers_scrub_props.sv
/*
  Port checker for the scrub controller, bound into it from tb_top.
  Assumes one clock, sync active-low reset, shared clocks.
*/
`timescale 1ns/1ns
`default_nettype none

module ers_scrub_props
  import ers_pkg::*;
#(
  parameter int PRESCALE_WIDTH = 2,
  parameter int TIMEOUT_COUNT = 4,
  parameter ers_pkg::ers_addr_t SCRUB_END_ADDR = '0,
  parameter int RESUME_CYC = 4
)(
  input wire logic clk,
  input wire logic rst_n,
  input wire logic userAccessHold,
  input wire logic rdValid,
  input wire ers_pkg::ers_word_t rdData,
  input wire ers_pkg::ers_addr_t ramAddr,
  input wire logic ramWen,
  input wire logic ramWrZero,
  input wire logic userWrBlock,
  input wire ers_pkg::ers_word_t rdDataOut,
  input wire ers_pkg::ers_flags_s userFlags,
  input wire logic timeoutPulse,
  input wire logic scrubActive,
  input wire logic scrubFix,
  input wire logic scrubFinished,
  input wire logic initDone
);
  // ----------------------------------------
  // Helper counters
  // ----------------------------------------
  int gap;
  int lowCnt;
  logic seen;

  // Gap since last timeout; saturating run of quiet hold cycles
  always_ff @(posedge clk)
  begin
    if (!rst_n)
    begin
      gap <= 0;
      seen <= 1'b0;
      lowCnt <= 0;
    end
    else
    begin
      gap <= timeoutPulse ? 0 : gap + 1;
      seen <= seen | timeoutPulse;
      lowCnt <= userAccessHold ? 0 : (lowCnt < 15 ? lowCnt + 1 : 15);
    end
  end

  // ----------------------------------------
  // Properties
  // ----------------------------------------
  default clocking cb @(posedge clk); endclocking
  default disable iff (!rst_n);
  sequence holdLong;
    userAccessHold [*8];
  endsequence
  sequence fixWrite;
    ramWen && !ramWrZero && initDone;
  endsequence

  timer_period_a: assert property (timeoutPulse && seen |->
    gap == TIMEOUT_COUNT * (2 ** PRESCALE_WIDTH) - 1) else $error("timeout period off");
  init_block_a: assert property (!initDone |-> userWrBlock)
    else $error("user writes open during init");
  init_last_a: assert property ($rose(initDone) |-> ramWen && ramWrZero &&
    ramAddr == SCRUB_END_ADDR) else $error("init done not on last write");
  init_wr_block_a: assert property (ramWen && ramWrZero |-> userWrBlock)
    else $error("user writes open during fill write");
  init_sticky_a: assert property (initDone |=> initDone)
    else $error("init done dropped");
  fin_pulse_a: assert property (scrubFinished |=> !scrubFinished)
    else $error("finished pulse too long");
  hold_quiet_a: assert property (holdLong |-> !scrubActive)
    else $error("scrubbing during user access");
  resume_gap_a: assert property ($rose(scrubActive) |-> lowCnt >= RESUME_CYC)
    else $error("scrub began too soon after access");
  fix_after_wb_a: assert property (fixWrite |-> ##[1:5] scrubFix)
    else $error("no fix flag after writeback");
  rd_path_a: assert property (rdValid |=> rdDataOut == $past(rdData))
    else $error("read data not passed on");
  flags_quiet_a: assert property (scrubActive && $past(scrubActive) |->
    userFlags == 2'h0) else $error("user flags during scrub");

endmodule : ers_scrub_props

`default_nettype wire

// ===== ers_user_model.sv
/*
  User logic and read path beside the protected RAM: access hold, user
  reads, decoder flags for scrub reads after the read latency.
  Assumes shared clock; inputs driven by tb_top.
*/
`timescale 1ns/1ns
`default_nettype none

module ers_user_model
  import ers_pkg::*;
#(
  parameter int RDLAT_CYC = 2
)(
  input wire logic clk,
  input wire logic ramRen,
  input wire logic holdReq,
  input wire logic rdReq,
  input wire ers_pkg::ers_word_t rdWord,
  input wire ers_pkg::ers_flags_s rdFl,
  input wire ers_pkg::ers_flags_s errPat,
  output logic userAccessHold,
  output logic rdValid,
  output ers_pkg::ers_word_t rdData,
  output ers_pkg::ers_flags_s decFlags
);
  // ----------------------------------------
  // Read latency and hold
  // ----------------------------------------
  logic [RDLAT_CYC-1:0] lat = '0;
  ers_word_t last = '0;

  // Idle data toggles so a stale word never looks valid
  always @(posedge clk)
  begin
    lat <= {lat[RDLAT_CYC-2:0], ramRen};
    userAccessHold <= holdReq;
    last <= rdReq ? rdWord : ~last;
  end

  // Scrub reads see the injected flag pair after the latency
  assign rdValid = rdReq;
  assign rdData = rdReq ? rdWord : last;
  assign decFlags = rdReq ? rdFl : (lat[RDLAT_CYC-1] ? errPat : 2'h0);

endmodule : ers_user_model

`default_nettype wire

// ===== tb_top.sv
/*
  Self-checking bench of the scrub controller with the user model.
  Assumes 20 MHz clock; short timer and an 8-word range for speed.
*/
`timescale 1ns/1ns
`default_nettype none

module tb_top;
  import ers_pkg::*;
  // ----------------------------------------
  // Setup
  // ----------------------------------------
  localparam int PW = 3;
  localparam int TC = 16;
  logic clk = 1'b0;
  logic rst_n;
  logic holdReq;
  logic rdReq;
  ers_word_t rdWord;
  ers_flags_s rdFl;
  ers_flags_s errPat;
  ers_word_t rdData, rdDataOut, w;
  ers_flags_s decFlags, userFlags;
  ers_addr_t ramAddr;
  logic userAccessHold, rdValid, ramRen, ramWen, ramWrZero, userWrBlock, timeoutPulse;
  logic scrubActive, scrubFix, scrubFinished, scrubDeferred, initDone;
  logic rdPrev = 1'b0;
  logic finPrev = 1'b0;
  logic [1:0] codes[3] = '{2'h0, 2'h2, 2'h1};
  logic [1:0] f;
  int n_mismatch = 0;
  int n_tests = 0;
  int nFix = 0;
  int nInit = 0;
  int cyc;
  logic [40:0] readQ[$];
  logic [8:0] sessQ[$];

  initial
  begin
    forever #25 clk = ~clk;
  end

  ers_scrub_ctrl #(.PRESCALE_WIDTH(PW), .TIMEOUT_COUNT(TC), .SCRUB_END_ADDR(10'h007)) u_dut (.*);
  ers_user_model u_user (.*);

  // ----------------------------------------
  // Tasks
  // ----------------------------------------
  task chkRead(input logic [40:0] got, input logic [40:0] exp);
    n_tests++;
    if (got !== exp)
    begin
      n_mismatch++;
      $display("mismatch t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask : chkRead

  task chkSess(input logic [8:0] got, input logic [8:0] exp);
    n_tests++;
    if (got !== exp)
    begin
      n_mismatch++;
      $display("mismatch t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask : chkSess

  task summarize;
    $display("counts: tests=%0d mismatches=%0d", n_tests, n_mismatch);
    if (n_mismatch == 0 && n_tests > 0)
      $display("TB: PASS");
    else
      $display("TB: FAIL");
    $finish;
  endtask : summarize

  // Bounded wait: 0 timeout, 1 finished, 2 init done
  task waitEv(input int which, input int lim, output int n);
    logic hit;
    hit = 1'b0;
    n = 0;
    while (!hit)
    begin
      @(posedge clk);
      n++;
      hit = (which == 0 && timeoutPulse === 1'b1) || (which == 1 && scrubFinished === 1'b1)
        || (which == 2 && initDone === 1'b1);
      if (n > lim)
      begin
        n_mismatch++;
        summarize();
      end
    end
  endtask : waitEv

  // ----------------------------------------
  // Monitor: pops the oldest note per result
  // ----------------------------------------
  always @(posedge clk)
  begin
    if (ramWen === 1'b1 && ramWrZero === 1'b1 && userWrBlock === 1'b1)
      nInit++;
    if (scrubFix === 1'b1)
      nFix++;
    if (rdPrev === 1'b1)
      chkRead({rdDataOut, userFlags}, readQ.pop_front());
    if (scrubFinished === 1'b1 && finPrev !== 1'b1)
    begin
      chkSess({scrubDeferred, nFix[7:0]}, sessQ.pop_front());
      nFix = 0;
    end
    rdPrev = rdValid;
    finPrev = scrubFinished;
  end

  // ----------------------------------------
  // Main sequence
  // ----------------------------------------
  initial
  begin
    void'($urandom(66));
    rst_n <= 1'b0;
    holdReq <= 1'b0;
    rdReq <= 1'b0;
    rdWord <= '0;
    rdFl <= '0;
    errPat <= '0;
    repeat (2) @(posedge clk);
    rst_n <= 1'b1;
    waitEv(2, 64, cyc);
    @(posedge clk);
    chkSess(9'(nInit), 9'h008);
    $display("test init done");
    sessQ.push_back(9'h000);
    sessQ.push_back(9'h000);
    waitEv(0, 300, cyc);
    waitEv(0, 300, cyc);
    chkSess(9'(cyc), 9'h080);
    waitEv(1, 100, cyc);
    $display("test timer done");
    // Every scrub read reports a corrected word
    errPat <= 2'h2;
    sessQ.push_back(9'h008);
    waitEv(1, 300, cyc);
    errPat <= 2'h0;
    $display("test writeback done");
    // Long access spans timeouts; reads with random words and flags
    holdReq <= 1'b1;
    repeat (150)
    begin
      w = ers_word_t'({$urandom, $urandom});
      f = codes[$urandom % 3];
      rdReq <= 1'b1;
      rdWord <= w;
      rdFl <= f;
      readQ.push_back({w, f});
      @(posedge clk);
    end
    rdReq <= 1'b0;
    waitEv(0, 300, cyc);
    holdReq <= 1'b0;
    sessQ.push_back(9'h100);
    waitEv(1, 300, cyc);
    $display("test deferred done");
    // Access cuts into a running session, which must still complete
    sessQ.push_back(9'h000);
    waitEv(0, 300, cyc);
    repeat (14) @(posedge clk);
    holdReq <= 1'b1;
    repeat (12) @(posedge clk);
    holdReq <= 1'b0;
    waitEv(1, 300, cyc);
    $display("test suspend done");
    summarize();
  end

endmodule : tb_top

bind ers_scrub_ctrl ers_scrub_props #(.PRESCALE_WIDTH(PRESCALE_WIDTH),
  .TIMEOUT_COUNT(TIMEOUT_COUNT), .SCRUB_END_ADDR(SCRUB_END_ADDR), .RESUME_CYC(RESUME_CYC))
  u_props (.*);

`default_nettype wire
